// ---- core/dpld_pkg.sv ----
/*
  Shared constants and types of the dual-port link decoder: register map,
  field positions, reset values, timing counts, symbol tables and carriers.
  Assumes a 125 MHz system clock and a classic Wishbone register bus.
*/
// Overview of operation
// - Firmware selects exactly one active input port by a control bit.
// - Only the selected port's receive circuitry is enabled; the other stays off.
// - Lane symbols decode 10-to-8 for video and 10-to-4 for islands.
// - Link clock rates up to a quarter of the 125 MHz clk_i are accepted by the symbol decoder.
// - Words carry a 10/12-bit colour depth tag besides plain 8-bit video.
// - Stopped link clock and stopped video are detected and reported to software.
// - Software may order power-down; the receiver then stops all decoding.
// - Each port's +5 V presence line is visible in a pollable status register.
// - Once out of reset, exactly one display data channel is connected, the other disabled; reset clears both enables.
// - A mask is advanced on each decoded video or island word and XORed with received data.
// - Stored keys feed decryption and never read back over the bus.
// - Each decrypted word is classed video, audio or auxiliary and tagged so in the one output stream.
package dpld_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] KEY0_OFS = 8'h08;
  localparam logic [7:0] KEY1_OFS = 8'h0C;

  // Control fields
  localparam int CTRL_PORT_BIT = 0;
  localparam int CTRL_PDOWN_BIT = 1;
  localparam int CTRL_CRYPT_BIT = 2;
  localparam int CTRL_DEPTH_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h02;

  // Status fields
  localparam int ST_PLUS5V_LSB = 0;
  localparam int ST_CLKSTOP_BIT = 2;
  localparam int ST_VIDSTOP_BIT = 3;
  localparam int ST_OVF_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_PORT_BIT = 6;
  localparam int ST_CLKRUN_BIT = 7;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int LINK_MAX_MHZ = 225;
  localparam int CLK_STOP_NS = 1000;
  localparam int CLK_STOP_CYC = (CLK_STOP_NS * CLK_MHZ + 999) / 1000;
  localparam int VID_STOP_SYM = 2048;
  localparam int RESYNC_EDGES = 8;
  localparam int VID_GUARD_SYM = 2;
  localparam int PKT_WORDS = 32;
  localparam int HDR_BITS = 8;
  localparam logic [7:0] AUDIO_PKT_TYPE = 8'h02;
  localparam logic [23:0] MASK_SEED_OR = 24'h000001;

  // ==========================================================================
  // Symbol tables
  localparam logic [9:0] CTL_TOKEN [4] = '{10'h354, 10'h0AB, 10'h154, 10'h2AB};
  localparam logic [9:0] TERC4_CODE [16] = '{
    10'h29C, 10'h263, 10'h2E4, 10'h2E2, 10'h171, 10'h11E, 10'h18E, 10'h13C,
    10'h2CC, 10'h139, 10'h19C, 10'h2C6, 10'h28E, 10'h271, 10'h163, 10'h2C3};
  localparam logic [3:0] PRE_VIDEO = 4'h1;
  localparam logic [3:0] PRE_ISLAND = 4'h5;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {WK_VIDEO, WK_AUDIO, WK_AUX} dpld_kind_t;

  typedef struct packed {
    dpld_kind_t kind;
    logic [1:0] depth;
    logic [23:0] data;
  } dpld_word_t;

  typedef struct packed {
    logic ctl;
    logic [1:0] c;
    logic terc_ok;
    logic [3:0] terc;
    logic [7:0] vid;
  } dpld_lane_t;

endpackage

// ---- core/dpld_lane_dec.sv ----
/*
  One lane's symbol decoder: control token, island nibble and video byte
  views of a 10-bit symbol, all produced at once.
  Assumes the symbol is stable while the caller uses the result.
*/
`timescale 1ns/10ps
module dpld_lane_dec (
  input wire logic [9:0] sym_i,
  output dpld_pkg::dpld_lane_t dec_o
);

  logic [7:0] d;

  // ==========================================================================
  // Decode
  always_comb begin
    dec_o = '0;
    d = sym_i[9] ? ~sym_i[7:0] : sym_i[7:0];
    dec_o.vid[0] = d[0];
    for (int i = 1; i < 8; i++) begin
      dec_o.vid[i] = sym_i[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
    end
    for (int k = 0; k < 4; k++) begin
      if (sym_i == dpld_pkg::CTL_TOKEN[k]) begin
        dec_o.ctl = 1'b1;
        dec_o.c = 2'(k);
      end
    end
    for (int k = 0; k < 16; k++) begin
      if (sym_i == dpld_pkg::TERC4_CODE[k]) begin
        dec_o.terc_ok = 1'b1;
        dec_o.terc = 4'(k);
      end
    end
  end

endmodule

// ---- core/dpld_fifo.sv ----
/*
  Word FIFO with flip-flop storage and a registered output stage.
  Assumes one clock; both sides use valid and ready.
*/
`timescale 1ns/10ps
module dpld_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  // ==========================================================================
  // Storage and pointers
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ==========================================================================
  // Output stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rp];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule

// ---- core/dpld_core.sv ----
/*
  Dual-port link decoder: port selection, pin synchronisers, symbol decode,
  period tracking, XOR decryption mask, word classing, stop detection,
  Wishbone register slave and output FIFO.
  Assumes link pins and link clocks are asynchronous to clk_i, symbols change
  away from the link clock's rising edge, and the link clock runs at most a
  quarter of clk_i so the sampler sees every edge.
*/
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module dpld_core #(
  parameter int VID_STOP = dpld_pkg::VID_STOP_SYM,
  parameter int RESYNC = dpld_pkg::RESYNC_EDGES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link pins, one set per port
  input wire logic [1:0] lnk_clk_i,
  input wire logic [29:0] lnk_sym0_i,
  input wire logic [29:0] lnk_sym1_i,
  input wire logic [1:0] plus5v_i,
  output logic [1:0] rx_en_o,
  output logic [1:0] ddc_en_o,
  output logic pdown_o,
  // Decoded word stream
  output logic word_valid_o,
  input wire logic word_ready_i,
  output dpld_pkg::dpld_word_t word_o
);

  typedef enum logic [2:0] {S_OFF, S_SYNC, S_CTL, S_VIDEO, S_ISLAND} dpld_state_t;

  localparam int SYNC_W = 32;

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pin_raw [2];
  logic [SYNC_W-1:0] pin_s1 [2];
  logic [SYNC_W-1:0] pin_s2 [2];
  logic [1:0] lclk_prev;
  logic [1:0] lclk_rise;

  assign pin_raw[0] = {plus5v_i[0], lnk_clk_i[0], lnk_sym0_i};
  assign pin_raw[1] = {plus5v_i[1], lnk_clk_i[1], lnk_sym1_i};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1[0] <= '0;
      pin_s1[1] <= '0;
      pin_s2[0] <= '0;
      pin_s2[1] <= '0;
      lclk_prev <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        pin_s1[p] <= pin_raw[p];
        pin_s2[p] <= pin_s1[p];
        lclk_prev[p] <= pin_s2[p][30];
      end
    end
  end

  assign lclk_rise[0] = pin_s2[0][30] && !lclk_prev[0];
  assign lclk_rise[1] = pin_s2[1][30] && !lclk_prev[1];

  // ==========================================================================
  // Registers
  logic port_sel;
  logic pdown;
  logic crypt_en;
  logic [1:0] depth;
  logic [31:0] key0;
  logic [31:0] key1;
  logic clk_stop_flag;
  logic vid_stop_flag;
  logic ovf_flag;
  logic wb_req;
  logic wb_wr;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  dpld_state_t state;
  logic active_port;
  logic clk_run;
  logic set_clk_stop;
  logic set_vid_stop;
  logic set_ovf;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  assign ctrl_word = {24'h000000, 2'b00, depth, 1'b0, crypt_en, pdown, port_sel};

  localparam int ST_PLUS5V_LSB_I = dpld_pkg::ST_PLUS5V_LSB;

  always_comb begin
    status_word = '0;
    status_word[ST_PLUS5V_LSB_I+1:ST_PLUS5V_LSB_I] = {pin_s2[1][31], pin_s2[0][31]};
    status_word[dpld_pkg::ST_CLKSTOP_BIT] = clk_stop_flag;
    status_word[dpld_pkg::ST_VIDSTOP_BIT] = vid_stop_flag;
    status_word[dpld_pkg::ST_OVF_BIT] = ovf_flag;
    status_word[dpld_pkg::ST_LOCK_BIT] = (state == S_CTL) || (state == S_VIDEO)
                                         || (state == S_ISLAND);
    status_word[dpld_pkg::ST_PORT_BIT] = active_port;
    status_word[dpld_pkg::ST_CLKRUN_BIT] = clk_run;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == dpld_pkg::CTRL_OFS) begin
          wb_dat_o <= ctrl_word;
        end else if (wb_adr_i == dpld_pkg::STATUS_OFS) begin
          wb_dat_o <= status_word;
        end else begin
          wb_dat_o <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_sel <= dpld_pkg::CTRL_RESET[dpld_pkg::CTRL_PORT_BIT];
      pdown <= dpld_pkg::CTRL_RESET[dpld_pkg::CTRL_PDOWN_BIT];
      crypt_en <= dpld_pkg::CTRL_RESET[dpld_pkg::CTRL_CRYPT_BIT];
      depth <= dpld_pkg::CTRL_RESET[dpld_pkg::CTRL_DEPTH_LSB+1:dpld_pkg::CTRL_DEPTH_LSB];
    end else if (wb_wr && wb_sel_i[0] && wb_adr_i == dpld_pkg::CTRL_OFS) begin
      port_sel <= wb_dat_i[dpld_pkg::CTRL_PORT_BIT];
      pdown <= wb_dat_i[dpld_pkg::CTRL_PDOWN_BIT];
      crypt_en <= wb_dat_i[dpld_pkg::CTRL_CRYPT_BIT];
      depth <= wb_dat_i[dpld_pkg::CTRL_DEPTH_LSB+1:dpld_pkg::CTRL_DEPTH_LSB];
    end
  end

  // Keys are write-only storage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key0 <= '0;
      key1 <= '0;
    end else if (wb_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == dpld_pkg::KEY0_OFS) begin
          key0[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
        if (wb_sel_i[b] && wb_adr_i == dpld_pkg::KEY1_OFS) begin
          key1[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  logic st_clr;
  assign st_clr = wb_wr && wb_sel_i[0] && wb_adr_i == dpld_pkg::STATUS_OFS;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_stop_flag <= 1'b0;
      vid_stop_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      clk_stop_flag <= set_clk_stop ||
        (clk_stop_flag && !(st_clr && wb_dat_i[dpld_pkg::ST_CLKSTOP_BIT]));
      vid_stop_flag <= set_vid_stop ||
        (vid_stop_flag && !(st_clr && wb_dat_i[dpld_pkg::ST_VIDSTOP_BIT]));
      ovf_flag <= set_ovf ||
        (ovf_flag && !(st_clr && wb_dat_i[dpld_pkg::ST_OVF_BIT]));
    end
  end

  // ==========================================================================
  // Selected port and lane decode
  logic cur_edge;
  logic [29:0] cur_sym;
  dpld_pkg::dpld_lane_t lane [3];

  // Only the active port is ever looked at
  assign cur_edge = (state != S_OFF) && lclk_rise[active_port];
  assign cur_sym = pin_s2[active_port][29:0];

  for (genvar g = 0; g < 3; g++) begin : g_lane
    dpld_lane_dec u_dec (
      .sym_i(cur_sym[g*10 +: 10]),
      .dec_o(lane[g])
    );
  end

  // ==========================================================================
  // Period tracking
  logic [3:0] preamble;
  logic [$clog2(dpld_pkg::VID_GUARD_SYM+1)-1:0] guard_left;
  logic [$clog2(RESYNC+1)-1:0] edge_cnt;
  logic all_ctl;
  logic emit_vid;
  logic emit_isl;

  assign all_ctl = lane[0].ctl && lane[1].ctl && lane[2].ctl;
  assign emit_vid = cur_edge && (state == S_VIDEO) && !lane[0].ctl && (guard_left == '0);
  assign emit_isl = cur_edge && (state == S_ISLAND) && !lane[0].ctl
                    && lane[1].terc_ok && lane[2].terc_ok;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_OFF;
      active_port <= 1'b0;
      edge_cnt <= '0;
      preamble <= '0;
      guard_left <= '0;
    end else if (pdown) begin
      state <= S_OFF;
    end else if (state == S_OFF || port_sel != active_port) begin
      state <= S_SYNC;
      active_port <= port_sel;
      edge_cnt <= '0;
      preamble <= '0;
    end else if (cur_edge) begin
      case (state)
        S_SYNC: begin
          if (edge_cnt == ($bits(edge_cnt))'(RESYNC - 1)) begin
            state <= S_CTL;
          end
          edge_cnt <= edge_cnt + 1'b1;
        end
        S_CTL: begin
          if (all_ctl) begin
            preamble <= {lane[2].c, lane[1].c};
          end else if (preamble == dpld_pkg::PRE_VIDEO) begin
            state <= S_VIDEO;
            guard_left <= ($bits(guard_left))'(dpld_pkg::VID_GUARD_SYM - 1);
          end else if (preamble == dpld_pkg::PRE_ISLAND) begin
            state <= S_ISLAND;
          end
        end
        S_VIDEO, S_ISLAND: begin
          if (lane[0].ctl) begin
            state <= S_CTL;
            preamble <= '0;
          end else if (guard_left != '0) begin
            guard_left <= guard_left - 1'b1;
          end
        end
        default: begin
          state <= S_OFF;
        end
      endcase
    end
  end

  // ==========================================================================
  // Decryption mask
  logic [23:0] mask;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask <= dpld_pkg::MASK_SEED_OR;
    end else if (state == S_SYNC || !crypt_en) begin
      mask <= key0[23:0] ^ key1[23:0] | dpld_pkg::MASK_SEED_OR;
    end else if (emit_vid || emit_isl) begin
      mask <= {mask[22:0], mask[23] ^ mask[22] ^ mask[21] ^ mask[16]};
    end
  end

  // ==========================================================================
  // Packet header tracking for island classing
  logic [$clog2(dpld_pkg::PKT_WORDS)-1:0] isl_idx;
  logic [dpld_pkg::HDR_BITS-1:0] pkt_type;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      isl_idx <= '0;
      pkt_type <= '0;
    end else if (state != S_ISLAND) begin
      isl_idx <= '0;
    end else if (emit_isl) begin
      isl_idx <= isl_idx + 1'b1;
      if (isl_idx < ($bits(isl_idx))'(dpld_pkg::HDR_BITS)) begin
        pkt_type[isl_idx[2:0]] <= lane[0].terc[2];
      end
    end
  end

  // ==========================================================================
  // Word build and hold stage
  dpld_pkg::dpld_word_t next_word;
  dpld_pkg::dpld_word_t hold;
  logic hold_valid;
  logic fifo_ready;
  logic [23:0] xmask;

  assign xmask = crypt_en ? mask : 24'h000000;

  always_comb begin
    next_word.depth = depth;
    if (emit_vid) begin
      next_word.kind = dpld_pkg::WK_VIDEO;
      next_word.data = {lane[2].vid, lane[1].vid, lane[0].vid} ^ xmask;
    end else begin
      next_word.data = {12'h000, lane[2].terc, lane[1].terc, lane[0].terc}
                       ^ {12'h000, xmask[11:0]};
      if (isl_idx >= ($bits(isl_idx))'(dpld_pkg::HDR_BITS)
          && pkt_type == dpld_pkg::AUDIO_PKT_TYPE) begin
        next_word.kind = dpld_pkg::WK_AUDIO;
      end else begin
        next_word.kind = dpld_pkg::WK_AUX;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_valid <= 1'b0;
      hold <= '0;
    end else if (state == S_SYNC) begin
      hold_valid <= 1'b0;
    end else if ((emit_vid || emit_isl) && (!hold_valid || fifo_ready)) begin
      hold_valid <= 1'b1;
      hold <= next_word;
    end else if (fifo_ready) begin
      hold_valid <= 1'b0;
    end
  end

  assign set_ovf = (emit_vid || emit_isl) && hold_valid && !fifo_ready;

  dpld_fifo #(
    .WIDTH($bits(dpld_pkg::dpld_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(hold_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(hold),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_o)
  );

  // ==========================================================================
  // Stop detection
  logic [$clog2(dpld_pkg::CLK_STOP_CYC+1)-1:0] idle_cyc;
  logic [$clog2(VID_STOP+1)-1:0] novid_sym;

  assign clk_run = idle_cyc < ($bits(idle_cyc))'(dpld_pkg::CLK_STOP_CYC);
  assign set_clk_stop = (state != S_OFF) && !clk_run;
  assign set_vid_stop = (state != S_OFF) &&
                        novid_sym == ($bits(novid_sym))'(VID_STOP);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cyc <= '0;
    end else if (state == S_OFF || cur_edge) begin
      idle_cyc <= '0;
    end else if (clk_run) begin
      idle_cyc <= idle_cyc + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      novid_sym <= '0;
    end else if (state == S_OFF || emit_vid) begin
      novid_sym <= '0;
    end else if (cur_edge && novid_sym != ($bits(novid_sym))'(VID_STOP)) begin
      novid_sym <= novid_sym + 1'b1;
    end
  end

  // ==========================================================================
  // Port enables
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_en_o <= '0;
      ddc_en_o <= '0;
      pdown_o <= 1'b1;
    end else begin
      rx_en_o[0] <= !pdown && (state != S_OFF) && !port_sel && !active_port;
      rx_en_o[1] <= !pdown && (state != S_OFF) && port_sel && active_port;
      ddc_en_o[0] <= !port_sel;
      ddc_en_o[1] <= port_sel;
      pdown_o <= pdown;
    end
  end

endmodule

// ---- tb/dpld_core_sva.sv ----
/*
  Port checker for dpld_core: port selection, power-down, bus answer, key hiding
  and the word stream handshake.
  Assumes binding to dpld_core; sees only its ports.
*/
`timescale 1ns/10ps
module dpld_core_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] rx_en_o,
  input wire logic [1:0] ddc_en_o,
  input wire logic pdown_o,
  input wire logic word_valid_o,
  input wire logic word_ready_i,
  input wire dpld_pkg::dpld_word_t word_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========================================================================
  // Port selection and power
  port_one_a: assert property (rx_en_o != 2'b11)
    else $error("both receive ports enabled");
  rx_sel_a: assert property (rx_en_o != 2'b00 |-> rx_en_o == ddc_en_o)
    else $error("receive enabled on an unselected port");
  ddc_one_a: assert property ($past(arst_n_i) |-> $onehot(ddc_en_o))
    else $error("channel enables not one-hot");
  pdown_off_a: assert property (pdown_o |-> rx_en_o == 2'b00)
    else $error("receiver enabled in power-down");
  // ==========================================================================
  // Register bus and stream
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  key_hide_a: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == dpld_pkg::KEY0_OFS ||
    wb_adr_i == dpld_pkg::KEY1_OFS) |-> wb_dat_o == 32'h0)
    else $error("key word readable");
  word_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
    else $error("word changed while stalled");
  kind_ok_a: assert property (word_valid_o |-> word_o.kind != 2'b11)
    else $error("word kind unknown");
endmodule
bind dpld_core dpld_core_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_en_o(rx_en_o), .ddc_en_o(ddc_en_o), .pdown_o(pdown_o),
  .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .word_o(word_o));

// ---- tb/dpld_src_model.sv ----
/*
  Source transmitter model for one link port: framed control, video and island symbols.
  Assumes the caller runs one frame at a time; the link clock stands still between frames.
*/
`timescale 1ns/10ps
module dpld_src_model (
  output logic lnk_clk_o,
  output logic [29:0] sym_o
);
  initial begin
    lnk_clk_o = 1'b0;
    sym_o = 30'h0;
  end
  function automatic logic [9:0] enc(input logic [7:0] d);
    logic [9:0] q;
    q = 10'h100;
    q[0] = d[0];
    for (int i = 1; i < 8; i++) q[i] = d[i] ^ q[i-1];
    return q;
  endfunction
  function automatic logic [29:0] ctl(input logic [3:0] p);
    return {dpld_pkg::CTL_TOKEN[p[3:2]], dpld_pkg::CTL_TOKEN[p[1:0]], dpld_pkg::CTL_TOKEN[0]};
  endfunction
  // Symbol changes on the falling edge, 80 ns link period
  task automatic tick(input logic [29:0] s);
    sym_o = s;
    #40 lnk_clk_o = 1'b1;
    #40 lnk_clk_o = 1'b0;
  endtask
  task automatic frame(input bit isl, input int n, input logic [7:0] b);
    logic [7:0] t;
    logic h;
    repeat (12) tick(ctl(isl ? dpld_pkg::PRE_ISLAND : dpld_pkg::PRE_VIDEO));
    if (isl) tick({3{dpld_pkg::TERC4_CODE[0]}});
    else repeat (2) tick({3{enc(8'h00)}});
    for (int i = 0; i < n; i++) begin
      t = b + 8'(isl ? i : 3 * i);
      h = (i < 8) ? dpld_pkg::AUDIO_PKT_TYPE[i] : 1'b0;
      if (isl) begin
        tick({dpld_pkg::TERC4_CODE[t[3:0] + 4'd2], dpld_pkg::TERC4_CODE[t[3:0] + 4'd1],
          dpld_pkg::TERC4_CODE[{1'b0, h, 2'b00}]});
      end else begin
        tick({enc(t + 8'd2), enc(t + 8'd1), enc(t)});
      end
    end
    repeat (2) tick(ctl(4'h0));
    // Released lines show a changed pattern
    sym_o = ~sym_o;
  endtask
endmodule

// ---- tb/dpld_core_tb.sv ----
/*
  Testbench for dpld_core: Wishbone register tasks and two source models.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
module dpld_core_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  wire [1:0] lclk;
  logic [29:0] s0;
  logic [29:0] s1;
  logic [1:0] rx_en;
  logic [1:0] ddc_en;
  logic pdown;
  logic wvalid;
  logic wready = 1'b1;
  logic [1:0] p5 = 2'b10;
  dpld_pkg::dpld_word_t word;
  dpld_pkg::dpld_word_t ew;
  dpld_pkg::dpld_word_t got[$];
  int error_cnt = 0;
  int check_count = 0;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
  dpld_core #(.VID_STOP(16), .RESYNC(2), .FIFO_DEPTH(16)) DUT (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lnk_clk_i(lclk),
    .lnk_sym0_i(s0), .lnk_sym1_i(s1), .plus5v_i(p5), .rx_en_o(rx_en), .ddc_en_o(ddc_en),
    .pdown_o(pdown), .word_valid_o(wvalid), .word_ready_i(wready), .word_o(word));
  dpld_src_model src0 (.lnk_clk_o(lclk[0]), .sym_o(s0));
  dpld_src_model src1 (.lnk_clk_o(lclk[1]), .sym_o(s1));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (wvalid && wready) got.push_back(word);
  // ==========================================================================
  // Tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) error_cnt++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic dpld_pkg::dpld_word_t vw(int i, logic [7:0] b);
    logic [7:0] t;
    t = b + 8'(3 * i);
    return {dpld_pkg::WK_VIDEO, 2'b10, t + 8'd2, t + 8'd1, t};
  endfunction
  function automatic logic [23:0] iw(int i, logic [7:0] b);
    logic [7:0] t;
    t = b + 8'(i);
    return {12'h0, t[3:0] + 4'd2, t[3:0] + 4'd1, 1'b0,
      (i < 8) ? dpld_pkg::AUDIO_PKT_TYPE[i] : 1'b0, 2'b00};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    `CHK({ddc_en, pdown}, 3'b011)
    bus(0, dpld_pkg::CTRL_OFS, 0);
    `CHK(q, 32'h2)
    bus(1, dpld_pkg::KEY0_OFS, 32'h00123456);
    bus(1, dpld_pkg::KEY1_OFS, 32'h00FF0F00);
    bus(0, dpld_pkg::KEY0_OFS, 0);
    `CHK(q, 32'h0)
    bus(0, 8'h10, 0);
    `CHK(q, 32'h0)
    bus(0, dpld_pkg::STATUS_OFS, 0);
    `CHK(q[1:0], 2'b10)
    bus(1, dpld_pkg::CTRL_OFS, 32'h20);
    wready <= 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(rx_en, 2'b01)
    src0.frame(0, 24, 8'h10);
    repeat (200) @(posedge clk_i);
    bus(0, dpld_pkg::STATUS_OFS, 0);
    `CHK({q[4], q[2]}, 2'b11)
    wready <= 1'b1;
    repeat (60) @(posedge clk_i);
    for (int k = 0; k < 16; k++) `CHK(got[k], vw(k, 8'h10))
    bus(1, dpld_pkg::STATUS_OFS, 32'h1C);
    bus(0, dpld_pkg::STATUS_OFS, 0);
    `CHK(q[4], 1'b0)
    got.delete();
    src0.frame(1, 9, 8'h30);
    repeat (200) @(posedge clk_i);
    `CHK(got.size(), 9)
    for (int k = 0; k < 9; k++) begin
      `CHK(got[k].kind, k < 8 ? dpld_pkg::WK_AUX : dpld_pkg::WK_AUDIO)
      `CHK(got[k].data, iw(k, 8'h30))
    end
    bus(0, dpld_pkg::STATUS_OFS, 0);
    `CHK(q[3], 1'b1)
    bus(1, dpld_pkg::CTRL_OFS, 32'h21);
    p5 <= 2'b01;
    repeat (2) @(negedge clk_i);
    `CHK({rx_en, ddc_en}, 4'hA)
    got.delete();
    src0.frame(0, 4, 8'h50);
    src1.frame(0, 4, 8'h60);
    repeat (60) @(posedge clk_i);
    `CHK(got.size(), 4)
    `CHK(got[0], vw(0, 8'h60))
    bus(0, dpld_pkg::STATUS_OFS, 0);
    `CHK(q[6], 1'b1)
    `CHK(q[1:0], 2'b01)
    bus(1, dpld_pkg::CTRL_OFS, 32'h25);
    got.delete();
    src1.frame(0, 2, 8'h70);
    repeat (60) @(posedge clk_i);
    ew = vw(0, 8'h70);
    `CHK(got[0].data, ew.data ^ 24'hED3B57)
    bus(1, dpld_pkg::CTRL_OFS, 32'h23);
    @(negedge clk_i);
    `CHK({pdown, rx_en}, 3'b100)
    got.delete();
    src1.frame(0, 2, 8'h70);
    repeat (60) @(posedge clk_i);
    `CHK(got.size(), 0)
    report_and_stop();
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule
